// *** verilog/fps_consts.vh ***
// constants for the flash program/erase sequencing host controller
`ifndef FPS_CONSTS_VH
`define FPS_CONSTS_VH
// avalon register offsets (word index)
`define FPS_REG_CTRL 4'h0
`define FPS_REG_ADDR 4'h1
`define FPS_REG_WDATA 4'h2
`define FPS_REG_RDATA 4'h3
`define FPS_REG_STATUS 4'h4
`define FPS_REG_IRQ_STAT 4'h5
`define FPS_REG_IRQ_MASK 4'h6
`define FPS_REG_CMD2 4'h7
// ctrl fields
`define FPS_CTRL_GO 0
`define FPS_CTRL_READ 1
`define FPS_CTRL_TWO 2
`define FPS_CTRL_POLL 3
`define FPS_CTRL_SUSP 4
`define FPS_CTRL_RESUME 5
`define FPS_CTRL_VPP 6
`define FPS_CTRL_RST 7
`define FPS_CTRL_CE_CTL 8
// irq bits
`define FPS_IRQ_DONE 0
`define FPS_IRQ_ERR 1
`define FPS_IRQ_REFUSE 2
`define FPS_IRQ_TIMEOUT 3
// status bit positions in the device status word
`define FPS_SR_READY 7
`define FPS_SR_ERR_MASK 16'h003A
// timing in ns or us and derived cycles at 100 ns
`define FPS_CLK_NS 100
`define FPS_WP_NS 60
`define FPS_WP_CYC ((`FPS_WP_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_RD_NS 85
`define FPS_RD_CYC ((`FPS_RD_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_ERES_US 500
`define FPS_ERES_CYC (`FPS_ERES_US * 1000 / `FPS_CLK_NS)
`define FPS_RST_US 22
`define FPS_RST_CYC (`FPS_RST_US * 1000 / `FPS_CLK_NS)
`define FPS_SUSP_US 20
`define FPS_SUSP_CYC (`FPS_SUSP_US * 1000 / `FPS_CLK_NS)
`endif

// *** verilog/fps_bus_cycle.v ***
// one strobe-framed write or read cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
module fps_bus_cycle #(
   parameter AW = 21,
   parameter DW = 16,
   parameter WP_CYC = 1,
   parameter RD_CYC = 1
) (
   // clock
   input wire clk_i,
   input wire sys_rst_i,
   input wire ce_i,
   // request
   input wire start_i,
   input wire wr_i,
   input wire ce_ctl_i,
   input wire [AW-1:0] addr_i,
   input wire [DW-1:0] wdata_i,
   output wire busy_o,
   output reg done_o,
   output reg [DW-1:0] rdata_o,
   // flash pins
   output reg [AW-1:0] f_addr_o,
   output reg f_ce_n_o,
   output reg f_we_n_o,
   output reg f_oe_n_o,
   input wire [DW-1:0] f_dq_i,
   output reg [DW-1:0] f_dq_o,
   output reg f_dq_oe_o
);
   localparam S_IDLE = 2'd0;
   localparam S_SETUP = 2'd1;
   localparam S_PULSE = 2'd2;
   localparam S_END = 2'd3;
   reg [1:0] st_r;
   reg [7:0] cnt_r;
   reg wr_r;
   reg ce_ctl_r;
   assign busy_o = (st_r != S_IDLE);
   always @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         st_r <= S_IDLE;
         cnt_r <= 8'h00;
         wr_r <= 1'b0;
         ce_ctl_r <= 1'b0;
         done_o <= 1'b0;
         rdata_o <= {DW{1'b0}};
         f_addr_o <= {AW{1'b0}};
         f_ce_n_o <= 1'b1;
         f_we_n_o <= 1'b1;
         f_oe_n_o <= 1'b1;
         f_dq_o <= {DW{1'b0}};
         f_dq_oe_o <= 1'b0;
      end
      else if (ce_i)
      begin
         done_o <= 1'b0;
         case (st_r)
            S_IDLE:
            begin
               if (start_i)
               begin
                  wr_r <= wr_i;
                  ce_ctl_r <= ce_ctl_i;
                  f_addr_o <= addr_i;
                  f_dq_o <= wdata_i;
                  f_dq_oe_o <= wr_i;
                  // the strobe not framing the cycle goes low first
                  if (wr_i)
                  begin
                     if (ce_ctl_i)
                        f_we_n_o <= 1'b0;
                     else
                        f_ce_n_o <= 1'b0;
                  end
                  else
                     f_ce_n_o <= 1'b0;
                  st_r <= S_SETUP;
               end
            end
            S_SETUP:
            begin
               // active period starts at the later falling strobe
               if (wr_r)
               begin
                  f_ce_n_o <= 1'b0;
                  f_we_n_o <= 1'b0;
                  cnt_r <= WP_CYC[7:0];
               end
               else
               begin
                  // read: oe and ce low, we held high
                  f_oe_n_o <= 1'b0;
                  f_we_n_o <= 1'b1;
                  cnt_r <= RD_CYC[7:0];
               end
               st_r <= S_PULSE;
            end
            S_PULSE:
            begin
               if (cnt_r <= 8'h01)
               begin
                  if (wr_r)
                  begin
                     // framing strobe rises first and latches the write
                     if (ce_ctl_r)
                        f_ce_n_o <= 1'b1;
                     else
                        f_we_n_o <= 1'b1;
                  end
                  else
                  begin
                     // single asynchronous read; no page bursts used
                     rdata_o <= f_dq_i;
                     f_oe_n_o <= 1'b1;
                  end
                  st_r <= S_END;
               end
               else
                  cnt_r <= cnt_r - 8'h01;
            end
            S_END:
            begin
               f_ce_n_o <= 1'b1;
               f_we_n_o <= 1'b1;
               f_oe_n_o <= 1'b1;
               f_dq_oe_o <= 1'b0;
               done_o <= 1'b1;
               st_r <= S_IDLE;
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end
endmodule // fps_bus_cycle
`default_nettype wire

// *** verilog/fps_timer.v ***
// down counter used for resume spacing and reset hold
`timescale 1ns/1ps
`default_nettype none
module fps_timer #(
   parameter W = 20
) (
   // clock
   input wire clk_i,
   input wire sys_rst_i,
   input wire ce_i,
   // control
   input wire load_i,
   input wire [W-1:0] count_i,
   output wire expired_o
);
   reg [W-1:0] cnt_r;
   assign expired_o = (cnt_r == {W{1'b0}});
   always @(posedge clk_i)
   begin
      if (sys_rst_i)
         cnt_r <= {W{1'b0}};
      else if (ce_i)
      begin
         if (load_i)
            cnt_r <= count_i;
         else if (!expired_o)
            cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule // fps_timer
`default_nettype wire

// *** verilog/fps_host.v ***
// host controller sequencing flash erase/program over async pins
// Function
// - cycle framed by chip-select or write strobe
// - poll status with ordinary read cycle
// - hold program supply until errors clear
// - 500 us from resume to suspend
// - command, second cycle, wait, read status
// - read: oe and ce low, we high
`timescale 1ns/1ps
`default_nettype none
`include "fps_consts.vh"
module fps_host #(
   parameter AW = 21,
   parameter DW = 16,
   parameter ERES_CYC = `FPS_ERES_CYC,
   parameter RST_CYC = `FPS_RST_CYC,
   parameter POLL_MAX = `FPS_SUSP_CYC
) (
   // clock and reset
   input wire clk_i,
   input wire sys_rst_i,
   input wire clk_en_i,
   // avalon-mm slave
   input wire [3:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   output reg [31:0] avs_readdata_o,
   output wire avs_waitrequest_o,
   output wire irq_o,
   // flash pins
   output wire [AW-1:0] f_addr_o,
   output wire f_ce_n_o,
   output wire f_we_n_o,
   output wire f_oe_n_o,
   input wire [DW-1:0] f_dq_i,
   output wire [DW-1:0] f_dq_o,
   output wire f_dq_oe_o,
   output reg f_rst_n_o,
   output reg f_vpp_en_o,
   input wire ready_busy_output_i
);
   localparam S_IDLE = 3'd0;
   localparam S_CMD1 = 3'd1;
   localparam S_CMD2 = 3'd2;
   localparam S_POLL = 3'd3;
   localparam S_WAITP = 3'd4;
   localparam S_RD = 3'd5;
   localparam S_RST = 3'd6;

   reg [2:0] st_r;
   reg [15:0] ctrl_r;
   reg [AW-1:0] addr_r;
   reg [DW-1:0] wdata_r;
   reg [DW-1:0] cmd2_r;
   reg [DW-1:0] rdata_r;
   reg [DW-1:0] sr_r;
   reg [3:0] irq_stat_r;
   reg [3:0] irq_mask_r;
   reg [3:0] irq_set_r;
   reg ack_r;
   reg cyc_start;
   reg cyc_wr;
   reg [AW-1:0] cyc_addr;
   reg [DW-1:0] cyc_wdata;
   reg [19:0] poll_cnt_r;
   reg erase_pending_r;
   reg tmr_load;
   reg [19:0] tmr_val;
   wire cyc_busy;
   wire cyc_done;
   wire [DW-1:0] cyc_rdata;
   wire tmr_exp;
   wire wr_hit;
   wire rd_hit;

   function sr_failed;
      input [DW-1:0] sr;
      begin
         sr_failed = |(sr & `FPS_SR_ERR_MASK);
      end
   endfunction

   assign wr_hit = avs_write_i && !ack_r;
   assign rd_hit = avs_read_i && !ack_r;
   // one wait cycle on every access; answer in the second cycle
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
   assign irq_o = |(irq_stat_r & irq_mask_r);

   fps_bus_cycle #(
      .AW(AW),
      .DW(DW),
      .WP_CYC(`FPS_WP_CYC),
      .RD_CYC(`FPS_RD_CYC)
   ) u_cyc (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(clk_en_i),
      .start_i(cyc_start),
      .wr_i(cyc_wr),
      .ce_ctl_i(ctrl_r[`FPS_CTRL_CE_CTL]),
      .addr_i(cyc_addr),
      .wdata_i(cyc_wdata),
      .busy_o(cyc_busy),
      .done_o(cyc_done),
      .rdata_o(cyc_rdata),
      .f_addr_o(f_addr_o),
      .f_ce_n_o(f_ce_n_o),
      .f_we_n_o(f_we_n_o),
      .f_oe_n_o(f_oe_n_o),
      .f_dq_i(f_dq_i),
      .f_dq_o(f_dq_o),
      .f_dq_oe_o(f_dq_oe_o)
   );

   fps_timer #(
      .W(20)
   ) u_tmr (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(clk_en_i),
      .load_i(tmr_load),
      .count_i(tmr_val),
      .expired_o(tmr_exp)
   );

   // sequencer launches bus cycles
   always @*
   begin
      cyc_start = 1'b0;
      cyc_wr = 1'b1;
      cyc_addr = addr_r;
      cyc_wdata = wdata_r;
      case (st_r)
         S_CMD1:
         begin
            cyc_start = !cyc_busy && !cyc_done;
         end
         S_CMD2:
         begin
            cyc_start = !cyc_busy && !cyc_done;
            cyc_wdata = cmd2_r;
         end
         S_POLL, S_RD:
         begin
            cyc_start = !cyc_busy && !cyc_done;
            cyc_wr = 1'b0;
         end
         default: cyc_start = 1'b0;
      endcase
   end

   always @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         st_r <= S_IDLE;
         ctrl_r <= 16'h0000;
         addr_r <= {AW{1'b0}};
         wdata_r <= {DW{1'b0}};
         cmd2_r <= {DW{1'b0}};
         rdata_r <= {DW{1'b0}};
         sr_r <= {DW{1'b0}};
         irq_stat_r <= 4'h0;
         irq_mask_r <= 4'h0;
         irq_set_r <= 4'h0;
         ack_r <= 1'b0;
         poll_cnt_r <= 20'h0_0000;
         erase_pending_r <= 1'b0;
         tmr_load <= 1'b0;
         tmr_val <= 20'h0_0000;
         avs_readdata_o <= 32'h0000_0000;
         f_rst_n_o <= 1'b0;
         f_vpp_en_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         irq_set_r <= 4'h0;
         tmr_load <= 1'b0;
         ack_r <= (avs_read_i || avs_write_i) && !ack_r;
         f_rst_n_o <= (st_r != S_RST);
         case (st_r)
            S_IDLE:
            begin
               if (wr_hit && avs_address_i == `FPS_REG_CTRL && avs_writedata_i[`FPS_CTRL_GO])
               begin
                  if (avs_writedata_i[`FPS_CTRL_RST])
                  begin
                     // hold reset long enough for a running operation to abort
                     tmr_val <= RST_CYC[19:0];
                     tmr_load <= 1'b1;
                     st_r <= S_RST;
                  end
                  else if (avs_writedata_i[`FPS_CTRL_READ])
                     st_r <= S_RD;
                  else if (avs_writedata_i[`FPS_CTRL_SUSP] && erase_pending_r && !tmr_exp)
                     irq_set_r[`FPS_IRQ_REFUSE] <= 1'b1; // too soon after resume
                  else if (!avs_writedata_i[`FPS_CTRL_SUSP] && !sr_r[`FPS_SR_READY] && ctrl_r[`FPS_CTRL_POLL])
                     irq_set_r[`FPS_IRQ_REFUSE] <= 1'b1; // device still busy
                  else
                  begin
                     if (avs_writedata_i[`FPS_CTRL_RESUME])
                     begin
                        tmr_val <= ERES_CYC[19:0];
                        tmr_load <= 1'b1;
                        erase_pending_r <= 1'b1;
                     end
                     // stale poll count would time a suspend out at once
                     poll_cnt_r <= 20'h0_0000;
                     // program supply raised ahead of the command
                     f_vpp_en_o <= f_vpp_en_o | avs_writedata_i[`FPS_CTRL_VPP];
                     st_r <= S_CMD1; // sequence begins with first cycle
                  end
               end
            end
            S_CMD1:
            begin
               if (cyc_done)
                  st_r <= ctrl_r[`FPS_CTRL_TWO] ? S_CMD2 : (ctrl_r[`FPS_CTRL_POLL] ? S_POLL : S_IDLE);
            end
            S_CMD2:
            begin
               // second cycle, a buffer word counts as its own write
               if (cyc_done)
               begin
                  poll_cnt_r <= 20'h0_0000;
                  st_r <= ctrl_r[`FPS_CTRL_POLL] ? S_POLL : S_IDLE;
               end
            end
            S_POLL:
            begin
               // status read uses the ordinary read cycle
               if (cyc_done)
               begin
                  sr_r <= cyc_rdata;
                  if (cyc_rdata[`FPS_SR_READY])
                  begin
                     irq_set_r[`FPS_IRQ_DONE] <= 1'b1; // ready also marks suspend done
                     if (sr_failed(cyc_rdata))
                        irq_set_r[`FPS_IRQ_ERR] <= 1'b1;
                     else
                        f_vpp_en_o <= 1'b0; // supply dropped only after clean status
                     st_r <= S_IDLE;
                  end
                  else if (ctrl_r[`FPS_CTRL_SUSP] && poll_cnt_r >= POLL_MAX[19:0])
                  begin
                     irq_set_r[`FPS_IRQ_TIMEOUT] <= 1'b1;
                     st_r <= S_IDLE;
                  end
                  else
                     st_r <= S_WAITP;
               end
               else
                  poll_cnt_r <= poll_cnt_r + 20'h0_0001;
            end
            S_WAITP:
            begin
               poll_cnt_r <= poll_cnt_r + 20'h0_0001;
               st_r <= S_POLL;
            end
            S_RD:
            begin
               if (cyc_done)
               begin
                  rdata_r <= cyc_rdata;
                  st_r <= S_IDLE;
               end
            end
            S_RST:
            begin
               erase_pending_r <= 1'b0;
               f_vpp_en_o <= 1'b0;
               if (tmr_exp && !tmr_load)
                  st_r <= S_IDLE;
            end
            default: st_r <= S_IDLE;
         endcase
         if (wr_hit)
         begin
            case (avs_address_i)
               `FPS_REG_CTRL: ctrl_r <= avs_writedata_i[15:0];
               `FPS_REG_ADDR: addr_r <= avs_writedata_i[AW-1:0];
               `FPS_REG_WDATA: wdata_r <= avs_writedata_i[DW-1:0];
               `FPS_REG_CMD2: cmd2_r <= avs_writedata_i[DW-1:0];
               `FPS_REG_IRQ_MASK: irq_mask_r <= avs_writedata_i[3:0];
               default: ;
            endcase
         end
         // events land one cycle late; set still wins over write-one-to-clear
         if (wr_hit && avs_address_i == `FPS_REG_IRQ_STAT)
            irq_stat_r <= (irq_stat_r & ~avs_writedata_i[3:0]) | irq_set_r;
         else
            irq_stat_r <= irq_stat_r | irq_set_r;
         if (rd_hit)
         begin
            case (avs_address_i)
               `FPS_REG_CTRL: avs_readdata_o <= {16'h0000, ctrl_r};
               `FPS_REG_ADDR: avs_readdata_o <= {{(32-AW){1'b0}}, addr_r};
               `FPS_REG_WDATA: avs_readdata_o <= {{(32-DW){1'b0}}, wdata_r};
               `FPS_REG_RDATA: avs_readdata_o <= {{(32-DW){1'b0}}, rdata_r};
               `FPS_REG_STATUS: avs_readdata_o <= {8'h00, ready_busy_output_i, f_vpp_en_o, erase_pending_r,
                                                  tmr_exp, st_r, (st_r != S_IDLE), sr_r};
               `FPS_REG_IRQ_STAT: avs_readdata_o <= {28'h000_0000, irq_stat_r};
               `FPS_REG_IRQ_MASK: avs_readdata_o <= {28'h000_0000, irq_mask_r};
               `FPS_REG_CMD2: avs_readdata_o <= {{(32-DW){1'b0}}, cmd2_r};
               default: avs_readdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // fps_host
`default_nettype wire

// *** test/fps_host_sva.sv ***
// concurrent checks on the flash host controller ports
`timescale 1ns/1ps
`default_nettype none
module fps_host_sva #(
   parameter AW = 21,
   parameter DW = 16,
   parameter RST_CYC = 220
) (
   // clock and bus
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   // flash pins
   input wire logic [AW-1:0] f_addr_o,
   input wire logic f_ce_n_o,
   input wire logic f_we_n_o,
   input wire logic f_oe_n_o,
   input wire logic [DW-1:0] f_dq_o,
   input wire logic f_dq_oe_o,
   input wire logic f_rst_n_o,
   input wire logic f_vpp_en_o,
   input wire logic ready_busy_output_i
);
   integer low_cnt;
   wire wr_act = !f_ce_n_o && !f_we_n_o;
   wire req = avs_read_i || avs_write_i;
   // sys reset preloads the count so the release edge is never judged short
   always @(posedge clk_i)
   begin
      if (sys_rst_i)
         low_cnt <= RST_CYC;
      else if (f_rst_n_o)
         low_cnt <= 0;
      else if (low_cnt < RST_CYC)
         low_cnt <= low_cnt + 1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   read_strobes_a: assert property (!f_oe_n_o |-> !f_ce_n_o && f_we_n_o)
      else $error("read strobe without select or with write strobe");
   read_release_a: assert property (!f_oe_n_o |-> !f_dq_oe_o)
      else $error("host drives data during read");
   write_pulse_a: assert property (wr_act |=> !wr_act)
      else $error("write active longer than one cycle");
   write_frame_a: assert property (wr_act |=> f_we_n_o != f_ce_n_o)
      else $error("write not ended by exactly one strobe");
   write_hold_a: assert property (wr_act |=> $stable(f_addr_o) && $stable(f_dq_o) && f_dq_oe_o)
      else $error("address or data moved at write end");
   vpp_hold_a: assert property (f_vpp_en_o && !ready_busy_output_i |=> f_vpp_en_o || !f_rst_n_o)
      else $error("program supply dropped while device busy");
   reset_hold_a: assert property ($rose(f_rst_n_o) |-> low_cnt >= RST_CYC - 1)
      else $error("flash reset pulse too short");
   wait_first_a: assert property ($rose(req) |-> avs_waitrequest_o)
      else $error("no wait state on new request");
   wait_once_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("more than one wait state");
   bus_idle_a: assert property (!req |-> !avs_waitrequest_o)
      else $error("waitrequest without request");
endmodule // fps_host_sva
bind fps_host fps_host_sva #(.AW(AW), .DW(DW), .RST_CYC(RST_CYC)) i_fps_host_sva (.clk_i, .sys_rst_i,
   .avs_read_i, .avs_write_i, .avs_waitrequest_o, .f_addr_o, .f_ce_n_o, .f_we_n_o, .f_oe_n_o,
   .f_dq_o, .f_dq_oe_o, .f_rst_n_o, .f_vpp_en_o, .ready_busy_output_i);
`default_nettype wire

// *** test/fps_flash_model.sv ***
// behavioural flash die answering the host controller
`timescale 1ns/1ps
`default_nettype none
module fps_flash_model #(
   parameter BUSY_CYC = 100,
   parameter SUSP_CYC = 5
) (
   // host side pins
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic vpp_i,
   input wire logic ce_n_i,
   input wire logic we_n_i,
   input wire logic oe_n_i,
   input wire logic [20:0] addr_i,
   input wire logic [15:0] dq_i,
   output logic [15:0] dq_o,
   output logic rb_o
);
   logic [20:0] lst_a = 21'h00_0000;
   logic [15:0] lst_d = 16'h0000;
   logic [15:0] sr = 16'h0080;
   logic [7:0] wr_cnt = 8'h00;
   logic [7:0] seen = 8'h00;
   logic arm = 1'b0;
   logic busy = 1'b0;
   logic pbuf = 1'b0;
   integer cnt = 0;
   wire act = !ce_n_i && !we_n_i;
   // latch on whichever strobe rises first
   always @(negedge act)
   begin
      lst_a <= addr_i;
      lst_d <= dq_i;
      wr_cnt <= wr_cnt + 8'h01;
      if (wr_cnt[3:0] == 4'hF)
         pbuf <= !pbuf;
   end
   // only single reads of the status word; released bus toggles so stale data never matches
   assign dq_o = (!ce_n_i && !oe_n_i && we_n_i) ? sr : (clk_i ? 16'hA5A5 : 16'h5A5A);
   assign rb_o = !busy;
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         busy <= 1'b0;
         arm <= 1'b0;
         sr <= 16'h0080;
         seen <= wr_cnt;
      end
      else if (wr_cnt != seen)
      begin
         seen <= wr_cnt;
         arm <= (lst_d == 16'h0020) || (lst_d == 16'h0040);
         if (lst_d == 16'h00B0 && busy)
            cnt <= SUSP_CYC;
         else if (arm && !vpp_i)
            sr <= 16'h0088;
         else if (arm)
         begin
            busy <= 1'b1;
            sr <= 16'h0000;
            cnt <= BUSY_CYC;
         end
      end
      else if (busy)
      begin
         cnt <= cnt - 1;
         if (cnt <= 1)
         begin
            busy <= 1'b0;
            sr <= 16'h0080;
         end
      end
   end
endmodule // fps_flash_model
`default_nettype wire

// *** test/tb.sv ***
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
`include "fps_consts.vh"
module tb;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [3:0] avs_address_i = 4'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0000_0000;
   wire [31:0] avs_readdata_o;
   wire avs_waitrequest_o, irq_o, f_ce_n_o, f_we_n_o, f_oe_n_o, f_dq_oe_o, f_rst_n_o, f_vpp_en_o, rb;
   wire [20:0] f_addr_o;
   wire [15:0] f_dq_o, mdq;
   wire [15:0] dq_bus = f_dq_oe_o ? f_dq_o : mdq;
   logic [31:0] q;
   logic [20:0] a;
   logic [15:0] d;
   logic [15:0] rnd = 16'h0B45; // 2885
   integer fails = 0;
   integer checks = 0;
   integer i;
   integer rst_lo = 0;
   fps_host #(.ERES_CYC(50), .RST_CYC(4), .POLL_MAX(50)) i_fps_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .clk_en_i(1'b1), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .irq_o(irq_o), .f_addr_o(f_addr_o), .f_ce_n_o(f_ce_n_o), .f_we_n_o(f_we_n_o), .f_oe_n_o(f_oe_n_o),
      .f_dq_i(dq_bus), .f_dq_o(f_dq_o), .f_dq_oe_o(f_dq_oe_o), .f_rst_n_o(f_rst_n_o), .f_vpp_en_o(f_vpp_en_o),
      .ready_busy_output_i(rb));
   fps_flash_model i_fps_flash_model (.clk_i(clk_i), .rst_n_i(f_rst_n_o), .vpp_i(f_vpp_en_o), .ce_n_i(f_ce_n_o),
      .we_n_i(f_we_n_o), .oe_n_i(f_oe_n_o), .addr_i(f_addr_o), .dq_i(dq_bus), .dq_o(mdq), .rb_o(rb));
   initial
   begin
      forever #50 clk_i = !clk_i;
   end
   // cycles the flash reset pin spends low after system reset
   always @(posedge clk_i)
   begin
      if (!sys_rst_i && !f_rst_n_o)
         rst_lo <= rst_lo + 1;
   end
   function automatic [15:0] lfsr(input logic [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task results;
      begin
         $display("checks=%0d fails=%0d", checks, fails);
         if (fails == 0 && checks > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp)
         begin
            fails = fails + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // request held until waitrequest is sampled low at a rising edge; read data taken at that edge
   task bus(input logic w, input logic [3:0] ad, input logic [31:0] wd, output logic [31:0] rd);
      integer n;
      begin
         n = 0;
         @(posedge clk_i);
         avs_address_i <= ad;
         avs_writedata_i <= wd;
         avs_write_i <= w;
         avs_read_i <= !w;
         @(posedge clk_i);
         while (avs_waitrequest_o !== 1'b0 && n < 50)
         begin
            n = n + 1;
            @(posedge clk_i);
         end
         if (n >= 50)
            chk(32'h0000_0001, 32'h0000_0000);
         rd = avs_readdata_o;
         avs_write_i <= 1'b0;
         avs_read_i <= 1'b0;
      end
   endtask
   task op(input logic [31:0] c, input logic [31:0] w1, input logic [31:0] w2);
      integer n;
      begin
         n = 0;
         bus(1'b1, `FPS_REG_ADDR, {11'h000, a}, q);
         bus(1'b1, `FPS_REG_WDATA, w1, q);
         bus(1'b1, `FPS_REG_CMD2, w2, q);
         bus(1'b1, `FPS_REG_CTRL, c, q);
         q = 32'hFFFF_FFFF;
         while (q[16] !== 1'b0 && n < 300)
         begin
            n = n + 1;
            bus(1'b0, `FPS_REG_STATUS, 32'h0000_0000, q);
         end
         if (n >= 300)
            chk(32'h0000_0001, 32'h0000_0000);
      end
   endtask
   initial
   begin
      repeat (16) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      bus(1'b0, 4'h9, 32'h0000_0000, q);
      chk(q, 32'h0000_0000);
      bus(1'b0, `FPS_REG_IRQ_STAT, 32'h0000_0000, q);
      chk(q, 32'h0000_0000);
      bus(1'b1, `FPS_REG_IRQ_MASK, 32'h0000_000F, q);
      // write-strobe framed then chip-select framed program, polled
      for (i = 0; i < 2; i = i + 1)
      begin
         rnd = lfsr(rnd);
         a = {rnd[4:0], rnd};
         rnd = lfsr(rnd);
         d = rnd;
         op(32'h0000_004D | (i << `FPS_CTRL_CE_CTL), 32'h0000_0040, {16'h0000, d});
         chk({11'h000, i_fps_flash_model.lst_a}, {11'h000, a});
         chk({16'h0000, i_fps_flash_model.lst_d}, {16'h0000, d});
         chk({16'h0000, q[15:0]}, 32'h0000_0080);
         chk({31'h0, irq_o}, 32'h0000_0001);
         bus(1'b1, `FPS_REG_IRQ_STAT, 32'h0000_000F, q);
         chk({31'h0, irq_o}, 32'h0000_0000);
      end
      // supply left low: device refuses, error reported and masked
      op(32'h0000_000D, 32'h0000_0020, 32'h0000_00D0);
      chk({16'h0000, q[15:0] & `FPS_SR_ERR_MASK}, 32'h0000_0008);
      bus(1'b0, `FPS_REG_IRQ_STAT, 32'h0000_0000, q);
      chk({31'h0, q[`FPS_IRQ_ERR]}, 32'h0000_0001);
      bus(1'b1, `FPS_REG_IRQ_MASK, 32'h0000_0000, q);
      chk({31'h0, irq_o}, 32'h0000_0000);
      bus(1'b1, `FPS_REG_IRQ_STAT, 32'h0000_000F, q);
      bus(1'b1, `FPS_REG_IRQ_MASK, 32'h0000_000F, q);
      // erase left running, then suspended
      op(32'h0000_0045, 32'h0000_0020, 32'h0000_00D0);
      chk({31'h0, q[23]}, 32'h0000_0000);
      op(32'h0000_0019, 32'h0000_00B0, 32'h0000_0000);
      chk({16'h0000, q[15:0]}, 32'h0000_0080);
      chk({31'h0, q[23]}, 32'h0000_0001);
      // resume then suspend too soon: refused
      op(32'h0000_0021, 32'h0000_00D0, 32'h0000_0000);
      op(32'h0000_0019, 32'h0000_00B0, 32'h0000_0000);
      bus(1'b0, `FPS_REG_IRQ_STAT, 32'h0000_0000, q);
      chk({31'h0, q[`FPS_IRQ_REFUSE]}, 32'h0000_0001);
      i = rst_lo;
      op(32'h0000_0081, 32'h0000_0000, 32'h0000_0000);
      chk({31'h0, f_rst_n_o}, 32'h0000_0001);
      chk({31'h0, (rst_lo - i) >= 4}, 32'h0000_0001);
      // single array read returns the status word of a freshly reset die
      op(32'h0000_0003, 32'h0000_0000, 32'h0000_0000);
      bus(1'b0, `FPS_REG_RDATA, 32'h0000_0000, q);
      chk(q, 32'h0000_0080);
      results;
   end
   initial
   begin
      repeat (30000) @(posedge clk_i);
      fails = fails + 1;
      results;
   end
endmodule // tb
`default_nettype wire
